//--- hdl/pdci_consts.svh
// Constants of the parallel digital command input block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef PDCI_CONSTS_SVH
`define PDCI_CONSTS_SVH

`define PDCI_CLK_PERIOD_NS     20
`define PDCI_SAMPLE_PERIOD_NS  1000000
`define PDCI_TICK_CYCLES       (`PDCI_SAMPLE_PERIOD_NS / `PDCI_CLK_PERIOD_NS)

`define PDCI_ADDR_CTRL         8'h00
`define PDCI_ADDR_SRC          8'h04
`define PDCI_ADDR_STATUS       8'h08
`define PDCI_ADDR_LIVE         8'h0c
`define PDCI_ADDR_WORD         8'h10

`define PDCI_CTRL_FMT_A        0
`define PDCI_CTRL_FMT_B        1
`define PDCI_CTRL_HOLD_A       2
`define PDCI_CTRL_HOLD_B       3
`define PDCI_CTRL_SPD_SEC      4
`define PDCI_CTRL_MASK         8'h1f
`define PDCI_CTRL_RESET        8'h00
`define PDCI_SRC_RESET         24'h000000

`define PDCI_SPD_CODE_A        4'h6
`define PDCI_SPD_CODE_B        4'h7
`define PDCI_TRQ_CODE_A        4'h2
`define PDCI_TRQ_CODE_B        4'h3

`define PDCI_BCD_W1000         14'h03e8
`define PDCI_BCD_W100          14'h0064
`define PDCI_BCD_W10           14'h000a
`define PDCI_BCD_MAX           14'h1f3f

`define PDCI_RESP_OKAY         2'h0
`define PDCI_RESP_SLVERR       2'h2

`endif

//--- hdl/pdci_pkg.sv
// Types of the parallel digital command input block.
// Assumes the constants header is on the include path.
`include "pdci_consts.svh"

package pdci_pkg;

  typedef struct packed {
    logic [15:0] m1;
    logic [15:0] m2;
    logic [15:0] live;
    logic [15:0] prev;
    logic [15:0] word;
    logic [2:0]  c1;
    logic [2:0]  c2;
    logic        pres;
    logic        slot_b;
  } pdci_card_t;

  typedef struct packed {
    logic [15:0]      tcnt;
    logic             tick;
    logic [1:0]       h1;
    logic [1:0]       h2;
    logic             aw_got;
    logic             w_got;
    logic [7:0]       awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic [7:0]       ctrl;
    logic [23:0]      src;
    logic [4:0][15:0] val;
    logic [4:0]       vld;
    logic             err;
    logic             sat;
  } pdci_state_t;

endpackage

//--- hdl/pdci_card.sv
// One card's contact capture: synchronise, polarity, two-sample agreement, hold.
// Assumes tick_in is a one-cycle pulse on the same clock.
`timescale 1ns/10ps
`include "pdci_consts.svh"

module pdci_card
  import pdci_pkg::*;
(
  input  wire logic        clk_in,                // System clock
  input  wire logic        reset_in,              // Async reset, high
  input  wire logic [15:0] contact_in,            // Raw contact pins
  input  wire logic        present_in,            // Card fitted pin
  input  wire logic        slot_select_switch_in, // 0 slot A, 1 slot B
  input  wire logic        sink_source_switch_in, // 0 sink, 1 source
  input  wire logic        tick_in,               // Sample tick
  input  wire logic        hold_on_in,            // High allows capture
  output logic             present_out,           // Card fitted
  output logic             slot_b_out,            // Card is slot B
  output logic [15:0]      live_out,              // Live active states
  output logic [15:0]      word_out               // Accepted word
);

  pdci_card_t st;
  pdci_card_t next_st;

  always_comb begin
    next_st = st;
    next_st.m1 = contact_in;
    next_st.m2 = st.m1;
    next_st.c1 = {present_in, slot_select_switch_in, sink_source_switch_in};
    next_st.c2 = st.c1;
    next_st.pres = st.c2[2];
    next_st.slot_b = st.c2[1];
    next_st.live = st.c2[0] ? st.m2 : ~st.m2;
    if (tick_in) begin
      next_st.prev = st.live;
      if (hold_on_in && st.live == st.prev) begin
        next_st.word = st.live;
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign present_out = st.pres;
  assign slot_b_out  = st.slot_b;
  assign live_out    = st.live;
  assign word_out    = st.word;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence s_sink_steady;
    (!sink_source_switch_in && $stable(contact_in))[*4];
  endsequence
  sequence s_source_steady;
    (sink_source_switch_in && $stable(contact_in))[*4];
  endsequence

  property p_sink;
    s_sink_steady |-> live_out == ~contact_in;
  endproperty
  a_sink: assert property (p_sink)
    else $error("sink polarity wrong");

  property p_source;
    s_source_steady |-> live_out == contact_in;
  endproperty
  a_source: assert property (p_source)
    else $error("source polarity wrong");

  property p_accept;
    tick_in && hold_on_in && st.live == st.prev |=> word_out == $past(st.live);
  endproperty
  a_accept: assert property (p_accept)
    else $error("agreeing samples not accepted");

  property p_reject;
    tick_in && st.live != st.prev |=> $stable(word_out);
  endproperty
  a_reject: assert property (p_reject)
    else $error("word changed on disagreeing samples");

  property p_hold;
    !hold_on_in |=> $stable(word_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("word changed while held");

  property p_no_tick;
    !tick_in |=> $stable(word_out) && $stable(st.prev);
  endproperty
  a_no_tick: assert property (p_no_tick)
    else $error("capture outside sample tick");

endmodule

//--- hdl/pdci_top.sv
// Drive-side command input: two card sockets, slot routing, decode, AXI4-Lite.
// Assumes asynchronous pins on the cards and hold inputs; AXI on SYS_CLK_IN.
`timescale 1ns/10ps
`include "pdci_consts.svh"

module pdci_top
  import pdci_pkg::*;
#(
  parameter int TICK_CYCLES = `PDCI_TICK_CYCLES
) (
  input  wire logic        SYS_CLK_IN,          // 50 MHz clock
  input  wire logic        RESET_IN,            // Async reset, high
  input  wire logic [15:0] CARD0_CONTACT_IN,    // Card 0 contacts
  input  wire logic        CARD0_PRESENT_IN,    // Card 0 fitted
  input  wire logic        CARD0_SLOT_SEL_IN,   // Card 0 slot switch
  input  wire logic        CARD0_SINK_SRC_IN,   // Card 0 polarity switch
  input  wire logic [15:0] CARD1_CONTACT_IN,    // Card 1 contacts
  input  wire logic        CARD1_PRESENT_IN,    // Card 1 fitted
  input  wire logic        CARD1_SLOT_SEL_IN,   // Card 1 slot switch
  input  wire logic        CARD1_SINK_SRC_IN,   // Card 1 polarity switch
  input  wire logic        HOLD_SLOT_A_IN,      // Slot A hold contact
  input  wire logic        HOLD_SLOT_B_IN,      // Slot B hold contact
  input  wire logic        AXI_AWVALID_IN,      // Write address valid
  output logic             AXI_AWREADY_OUT,     // Write address ready
  input  wire logic [7:0]  AXI_AWADDR_IN,       // Write address
  input  wire logic        AXI_WVALID_IN,       // Write data valid
  output logic             AXI_WREADY_OUT,      // Write data ready
  input  wire logic [31:0] AXI_WDATA_IN,        // Write data
  input  wire logic [3:0]  AXI_WSTRB_IN,        // Write strobes
  output logic             AXI_BVALID_OUT,      // Write response valid
  input  wire logic        AXI_BREADY_IN,       // Write response ready
  output logic [1:0]       AXI_BRESP_OUT,       // Write response
  input  wire logic        AXI_ARVALID_IN,      // Read address valid
  output logic             AXI_ARREADY_OUT,     // Read address ready
  input  wire logic [7:0]  AXI_ARADDR_IN,       // Read address
  output logic             AXI_RVALID_OUT,      // Read data valid
  input  wire logic        AXI_RREADY_IN,       // Read data ready
  output logic [31:0]      AXI_RDATA_OUT,       // Read data
  output logic [1:0]       AXI_RRESP_OUT,       // Read response
  output logic [15:0]      SPEED_VALUE_OUT,     // Speed setting
  output logic             SPEED_VALID_OUT,     // Speed setting in use
  output logic [15:0]      TORQUE_CMD_OUT,      // Torque command
  output logic             TORQUE_CMD_VALID_OUT, // Torque command in use
  output logic [15:0]      TORQUE_CUR_OUT,      // Torque current command
  output logic             TORQUE_CUR_VALID_OUT, // Torque current in use
  output logic [15:0]      TORQUE_LIM1_OUT,     // Torque limit one
  output logic             TORQUE_LIM1_VALID_OUT, // Limit one in use
  output logic [15:0]      TORQUE_LIM2_OUT,     // Torque limit two
  output logic             TORQUE_LIM2_VALID_OUT, // Limit two in use
  output logic             SPEED_AS_TORQUE_OUT, // Speed word taken as torque
  output logic             PROCEDURE_ERROR_OUT  // Both cards on one slot
);

  pdci_state_t st;
  pdci_state_t next_st;

  logic        c0_pres;
  logic        c0_b;
  logic        c1_pres;
  logic        c1_b;
  logic [15:0] live0;
  logic [15:0] live1;
  logic [15:0] w0;
  logic [15:0] w1;
  logic        hold0;
  logic        hold1;
  logic        a_from0;
  logic        b_from0;
  logic        pres_a;
  logic        pres_b;
  logic        conflict;
  logic [15:0] word_a;
  logic [15:0] word_b;
  logic [15:0] dec_a;
  logic [15:0] dec_b;
  logic [3:0]  spd_code;
  logic [4:0]  sel_a;
  logic [4:0]  sel_b;
  logic        awready;
  logic        wready;
  logic        arready;

  // Per-card capture; hold follows the slot the card claims
  pdci_card u_card0 (
    .clk_in                (SYS_CLK_IN),
    .reset_in              (RESET_IN),
    .contact_in            (CARD0_CONTACT_IN),
    .present_in            (CARD0_PRESENT_IN),
    .slot_select_switch_in (CARD0_SLOT_SEL_IN),
    .sink_source_switch_in (CARD0_SINK_SRC_IN),
    .tick_in               (st.tick),
    .hold_on_in            (hold0),
    .present_out           (c0_pres),
    .slot_b_out            (c0_b),
    .live_out              (live0),
    .word_out              (w0)
  );

  pdci_card u_card1 (
    .clk_in                (SYS_CLK_IN),
    .reset_in              (RESET_IN),
    .contact_in            (CARD1_CONTACT_IN),
    .present_in            (CARD1_PRESENT_IN),
    .slot_select_switch_in (CARD1_SLOT_SEL_IN),
    .sink_source_switch_in (CARD1_SINK_SRC_IN),
    .tick_in               (st.tick),
    .hold_on_in            (hold1),
    .present_out           (c1_pres),
    .slot_b_out            (c1_b),
    .live_out              (live1),
    .word_out              (w1)
  );

  function automatic logic [15:0] decode(input logic [15:0] w, input logic bcd);
    logic [13:0] m;
    m = 14'(w[14:12]) * `PDCI_BCD_W1000 + 14'(w[11:8]) * `PDCI_BCD_W100
      + 14'(w[7:4]) * `PDCI_BCD_W10 + 14'(w[3:0]);
    if (m > `PDCI_BCD_MAX) begin
      m = `PDCI_BCD_MAX;
    end
    if (!bcd) begin
      decode = w;
    end else if (w[15]) begin
      decode = 16'h0000 - {2'h0, m};
    end else begin
      decode = {2'h0, m};
    end
  endfunction

  assign hold0 = c0_b ? (!st.ctrl[`PDCI_CTRL_HOLD_B] || st.h2[1])
                      : (!st.ctrl[`PDCI_CTRL_HOLD_A] || st.h2[0]);
  assign hold1 = c1_b ? (!st.ctrl[`PDCI_CTRL_HOLD_B] || st.h2[1])
                      : (!st.ctrl[`PDCI_CTRL_HOLD_A] || st.h2[0]);
  assign a_from0  = c0_pres && !c0_b;
  assign b_from0  = c0_pres && c0_b;
  assign pres_a   = a_from0 || (c1_pres && !c1_b);
  assign pres_b   = b_from0 || (c1_pres && c1_b);
  assign conflict = c0_pres && c1_pres && (c0_b == c1_b);
  assign word_a   = a_from0 ? w0 : w1;
  assign word_b   = b_from0 ? w0 : w1;
  assign dec_a    = decode(word_a, st.ctrl[`PDCI_CTRL_FMT_A]);
  assign dec_b    = decode(word_b, st.ctrl[`PDCI_CTRL_FMT_B]);
  assign spd_code = st.ctrl[`PDCI_CTRL_SPD_SEC] ? st.src[7:4] : st.src[3:0];

  // Use 0 speed, 1 torque, 2 torque current, 3 limit one, 4 limit two
  generate
    for (genvar i = 0; i < 5; i++) begin : g_use
      if (i == 0) begin : g_spd
        assign sel_a[i] = spd_code == `PDCI_SPD_CODE_A;
        assign sel_b[i] = spd_code == `PDCI_SPD_CODE_B;
      end else begin : g_trq
        assign sel_a[i] = st.src[4*i+4 +: 4] == `PDCI_TRQ_CODE_A;
        assign sel_b[i] = st.src[4*i+4 +: 4] == `PDCI_TRQ_CODE_B;
      end
    end
  endgenerate

  assign awready = !st.aw_got && !st.bvalid;
  assign wready  = !st.w_got && !st.bvalid;
  assign arready = !st.rvalid;

  always_comb begin
    logic [31:0] rd;
    logic [1:0]  rr;
    logic        ua;
    logic        ub;
    rd = 32'h00000000;
    rr = `PDCI_RESP_OKAY;
    ua = 1'b0;
    ub = 1'b0;
    next_st = st;
    // Sample tick
    if (st.tcnt == 16'(TICK_CYCLES - 1)) begin
      next_st.tcnt = 16'h0000;
      next_st.tick = 1'b1;
    end else begin
      next_st.tcnt = st.tcnt + 16'h0001;
      next_st.tick = 1'b0;
    end
    next_st.h1 = {HOLD_SLOT_B_IN, HOLD_SLOT_A_IN};
    next_st.h2 = st.h1;
    // Routing of the decoded words
    for (int i = 0; i < 5; i++) begin
      ua = sel_a[i] && pres_a;
      ub = sel_b[i] && pres_b;
      next_st.val[i] = ub ? dec_b : (ua ? dec_a : 16'h0000);
      next_st.vld[i] = (ua || ub) && !conflict;
    end
    next_st.sat = (sel_a[0] && sel_a[1] && pres_a) || (sel_b[0] && sel_b[1] && pres_b);
    if (next_st.sat) begin
      next_st.vld[0] = 1'b0;
    end
    next_st.err = conflict;
    // Write channel
    if (AXI_AWVALID_IN && awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = AXI_AWADDR_IN;
    end
    if (AXI_WVALID_IN && wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = AXI_WDATA_IN;
      next_st.wstrb = AXI_WSTRB_IN;
    end
    if (st.bvalid && AXI_BREADY_IN) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_got && st.w_got) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = `PDCI_RESP_OKAY;
      unique case (st.awaddr)
        `PDCI_ADDR_CTRL: begin
          if (st.wstrb[0]) begin
            next_st.ctrl = st.wdata[7:0] & `PDCI_CTRL_MASK;
          end
        end
        `PDCI_ADDR_SRC: begin
          for (int b = 0; b < 3; b++) begin
            if (st.wstrb[b]) begin
              next_st.src[8*b +: 8] = st.wdata[8*b +: 8];
            end
          end
        end
        `PDCI_ADDR_STATUS, `PDCI_ADDR_LIVE, `PDCI_ADDR_WORD: begin
        end
        default: begin
          next_st.bresp = `PDCI_RESP_SLVERR;
        end
      endcase
    end
    // Read channel
    unique case (AXI_ARADDR_IN)
      `PDCI_ADDR_CTRL:   rd = {24'h000000, st.ctrl};
      `PDCI_ADDR_SRC:    rd = {8'h00, st.src};
      `PDCI_ADDR_STATUS: rd = {28'h0000000, st.sat, pres_b, pres_a, st.err};
      `PDCI_ADDR_LIVE:   rd = {live1, live0};
      `PDCI_ADDR_WORD:   rd = {word_b, word_a};
      default:           rr = `PDCI_RESP_SLVERR;
    endcase
    if (st.rvalid && AXI_RREADY_IN) begin
      next_st.rvalid = 1'b0;
    end
    if (AXI_ARVALID_IN && arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd;
      next_st.rresp  = rr;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      st      <= '0;
      st.ctrl <= `PDCI_CTRL_RESET;
      st.src  <= `PDCI_SRC_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign AXI_AWREADY_OUT       = awready;
  assign AXI_WREADY_OUT        = wready;
  assign AXI_BVALID_OUT        = st.bvalid;
  assign AXI_BRESP_OUT         = st.bresp;
  assign AXI_ARREADY_OUT       = arready;
  assign AXI_RVALID_OUT        = st.rvalid;
  assign AXI_RDATA_OUT         = st.rdata;
  assign AXI_RRESP_OUT         = st.rresp;
  assign SPEED_VALUE_OUT       = st.val[0];
  assign SPEED_VALID_OUT       = st.vld[0];
  assign TORQUE_CMD_OUT        = st.val[1];
  assign TORQUE_CMD_VALID_OUT  = st.vld[1];
  assign TORQUE_CUR_OUT        = st.val[2];
  assign TORQUE_CUR_VALID_OUT  = st.vld[2];
  assign TORQUE_LIM1_OUT       = st.val[3];
  assign TORQUE_LIM1_VALID_OUT = st.vld[3];
  assign TORQUE_LIM2_OUT       = st.val[4];
  assign TORQUE_LIM2_VALID_OUT = st.vld[4];
  assign SPEED_AS_TORQUE_OUT   = st.sat;
  assign PROCEDURE_ERROR_OUT   = st.err;

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);

  sequence s_wr_pair;
    st.aw_got && st.w_got;
  endsequence

  property p_conflict;
    conflict |=> PROCEDURE_ERROR_OUT && (st.vld == 5'h00);
  endproperty
  a_conflict: assert property (p_conflict)
    else $error("slot conflict not refused");

  property p_torque_a;
    sel_a[1] && pres_a && !conflict |=> TORQUE_CMD_VALID_OUT && TORQUE_CMD_OUT == $past(dec_a);
  endproperty
  a_torque_a: assert property (p_torque_a)
    else $error("torque command slot A not routed");

  property p_current_b;
    sel_b[2] && pres_b && !conflict |=> TORQUE_CUR_VALID_OUT && TORQUE_CUR_OUT == $past(dec_b);
  endproperty
  a_current_b: assert property (p_current_b)
    else $error("torque current slot B not routed");

  property p_speed;
    sel_b[0] && pres_b && !sel_b[1] && !conflict |=> SPEED_VALID_OUT && SPEED_VALUE_OUT == $past(dec_b);
  endproperty
  a_speed: assert property (p_speed)
    else $error("speed slot B not routed");

  property p_same_slot;
    sel_a[0] && sel_a[1] && pres_a && !conflict |=> SPEED_AS_TORQUE_OUT && !SPEED_VALID_OUT && TORQUE_CMD_VALID_OUT;
  endproperty
  a_same_slot: assert property (p_same_slot)
    else $error("shared slot not taken as torque");

  property p_bcd_range;
    st.ctrl[`PDCI_CTRL_FMT_A] |-> $signed(dec_a) <= $signed({2'h0, `PDCI_BCD_MAX})
                                && $signed(dec_a) >= -$signed({2'h0, `PDCI_BCD_MAX});
  endproperty
  a_bcd_range: assert property (p_bcd_range)
    else $error("BCD value out of range");

  property p_bcd_sign;
    st.ctrl[`PDCI_CTRL_FMT_A] && word_a == 16'h9999 |-> dec_a == 16'hf831;
  endproperty
  a_bcd_sign: assert property (p_bcd_sign)
    else $error("BCD sign or digits wrong");

  property p_binary;
    !st.ctrl[`PDCI_CTRL_FMT_B] |-> dec_b == word_b;
  endproperty
  a_binary: assert property (p_binary)
    else $error("binary decode not two's complement");

  property p_live_read;
    AXI_ARVALID_IN && arready && AXI_ARADDR_IN == `PDCI_ADDR_LIVE
      |=> AXI_RVALID_OUT && AXI_RDATA_OUT == {$past(live1), $past(live0)};
  endproperty
  a_live_read: assert property (p_live_read)
    else $error("live contact read wrong");

  property p_write_resp;
    s_wr_pair |=> AXI_BVALID_OUT && !st.aw_got && !st.w_got;
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("write response missing");

endmodule

//--- test/pdci_contact_src.sv
// Far-side model: an external source driving one card's contacts.
// Assumes the bench sets the word and holds it across two sample ticks.
`timescale 1ns/10ps

module pdci_contact_src (
  input  wire logic        clk_in,  // Bench clock
  input  wire logic [15:0] word_in, // Wanted active states
  input  wire logic        src_in,  // 0 sink, 1 source
  output logic [15:0]      pin_out  // Contact levels
);
  // Sink pulls an active contact low, source drives it high
  always_ff @(posedge clk_in) begin
    pin_out <= src_in ? word_in : ~word_in;
  end
endmodule

//--- test/parallel_digital_command_input_tb_top.sv
// Self-checking bench for the command input block with two cards.
// Assumes the short sample tick parameter and the block's AXI register map.
`timescale 1ns/10ps

module parallel_digital_command_input_tb_top;
  localparam int TK = 8;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] wa = 16'h0, wb = 16'h0, pa, pb, old, ob;
  logic        sb = 1'b1, ha = 1'b1, hb = 1'b1, pr1 = 1'b1, s0 = 1'b0, s1 = 1'b1;
  logic        awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic [1:0]  rs;
  logic [15:0] spd, trq, cur, l1, l2;
  logic [4:0]  vld;
  logic        sat, perr, awr, wr_r, bv, arr, rv;
  logic [1:0]  br, rr;
  logic [31:0] rdat;
  int          error_cnt = 0;
  int          checks = 0;

  always #10 clk = ~clk;

  pdci_contact_src i_src0 (.clk_in(clk), .word_in(wa), .src_in(s0), .pin_out(pa));
  pdci_contact_src i_src1 (.clk_in(clk), .word_in(wb), .src_in(s1), .pin_out(pb));

  pdci_top #(.TICK_CYCLES(TK)) i_dut (
    .SYS_CLK_IN(clk), .RESET_IN(rst),
    .CARD0_CONTACT_IN(pa), .CARD0_PRESENT_IN(1'b1), .CARD0_SLOT_SEL_IN(1'b0),
    .CARD0_SINK_SRC_IN(s0), .CARD1_CONTACT_IN(pb), .CARD1_PRESENT_IN(pr1),
    .CARD1_SLOT_SEL_IN(sb), .CARD1_SINK_SRC_IN(s1),
    .HOLD_SLOT_A_IN(ha), .HOLD_SLOT_B_IN(hb),
    .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awr), .AXI_AWADDR_IN(awa),
    .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wr_r), .AXI_WDATA_IN(wd), .AXI_WSTRB_IN(4'hf),
    .AXI_BVALID_OUT(bv), .AXI_BREADY_IN(brd), .AXI_BRESP_OUT(br),
    .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arr), .AXI_ARADDR_IN(ara),
    .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rrd), .AXI_RDATA_OUT(rdat), .AXI_RRESP_OUT(rr),
    .SPEED_VALUE_OUT(spd), .SPEED_VALID_OUT(vld[4]),
    .TORQUE_CMD_OUT(trq), .TORQUE_CMD_VALID_OUT(vld[3]),
    .TORQUE_CUR_OUT(cur), .TORQUE_CUR_VALID_OUT(vld[2]),
    .TORQUE_LIM1_OUT(l1), .TORQUE_LIM1_VALID_OUT(vld[1]),
    .TORQUE_LIM2_OUT(l2), .TORQUE_LIM2_VALID_OUT(vld[0]),
    .SPEED_AS_TORQUE_OUT(sat), .PROCEDURE_ERROR_OUT(perr)
  );

  // Reference decode: two's complement or signed BCD with clamp
  function automatic logic [15:0] dec(input logic [15:0] w, input bit bcd);
    int m;
    if (!bcd) return w;
    m = w[3:0] + 10 * w[7:4] + 100 * w[11:8] + 1000 * w[14:12];
    if (m > 7999) m = 7999;
    return w[15] ? 16'(-m) : 16'(m);
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ao, wo, bo;
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    brd <= 1'b1;
    do begin
      @(negedge clk);
      ao = awv && awr;
      wo = wv && wr_r;
      bo = bv;
      r = br;
      @(posedge clk);
      if (ao) awv <= 1'b0;
      if (wo) wv <= 1'b0;
    end while (!bo);
    brd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ao, ro;
    arv <= 1'b1;
    ara <= a;
    rrd <= 1'b1;
    do begin
      @(negedge clk);
      ao = arv && arr;
      ro = rv;
      d = rdat;
      r = rr;
      @(posedge clk);
      if (ao) arv <= 1'b0;
    end while (!ro);
    rrd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic settle();
    repeat (5 * TK) @(posedge clk);
  endtask

  task automatic outs(input logic [15:0] a, input logic [15:0] b);
    chk(32'(trq), 32'(dec(a, 0)));
    chk(32'(spd), 32'(dec(b, 1)));
    chk(32'(cur), 32'(dec(b, 1)));
    chk(32'(l1), 32'(dec(a, 0)));
    chk(32'(l2), 32'(dec(b, 1)));
    chk(32'(vld), 32'h1f);
    rdr(8'h10, rd, rs);
    chk(rd, {b, a});
    // Live states follow the contacts now driven, held or not
    rdr(8'h0c, rd, rs);
    chk(rd, {wb, wa});
  endtask

  task automatic conclude();
    $display("counts: checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge clk);
    error_cnt++;
    conclude();
  end

  initial begin
    void'($urandom(32'h4d33));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdr(8'h00, rd, rs);
    chk(rd, 32'h0);
    rdr(8'h14, rd, rs);
    chk(rd, 32'h0);
    chk(32'(rs), 32'h2);
    wr(8'h14, 32'h1, rs);
    chk(32'(rs), 32'h2);
    wr(8'h04, 32'h00323207, rs);
    wr(8'h00, 32'h02, rs);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      wa <= (i == 0) ? 16'h8000 : (i == 1) ? 16'h7fff : 16'($urandom);
      wb <= (i == 0) ? 16'h7fff : (i == 1) ? 16'h8000 : 16'($urandom);
      settle();
      outs(wa, wb);
    end
    $display("test decode done");
    old = wa;
    repeat (20) begin
      wa <= wa + 16'h1;
      repeat (3) @(posedge clk);
    end
    chk(32'(trq), 32'(dec(old, 0)));
    settle();
    outs(wa, wb);
    $display("test agreement done");
    wr(8'h00, 32'h0e, rs);
    ha <= 1'b0;
    hb <= 1'b0;
    settle();
    old = wa;
    ob = wb;
    wa <= ~old;
    wb <= ob ^ 16'h0011;
    settle();
    outs(old, ob);
    ha <= 1'b1;
    hb <= 1'b1;
    settle();
    outs(wa, wb);
    $display("test hold done");
    wr(8'h04, 32'h00323206, rs);
    settle();
    chk(32'({sat, vld[4], vld[3]}), 32'h5);
    chk(32'(trq), 32'(dec(wa, 0)));
    wr(8'h00, 32'h12, rs);
    wr(8'h04, 32'h00323276, rs);
    settle();
    chk(32'({sat, vld[4]}), 32'h1);
    chk(32'(spd), 32'(dec(wb, 1)));
    $display("test routing done");
    wr(8'h00, 32'h13, rs);
    for (int i = 0; i < 2; i++) begin
      wa <= (i == 0) ? 16'h9999 : 16'($urandom);
      settle();
      chk(32'(trq), 32'(dec(wa, 1)));
      chk(32'(l1), 32'(dec(wa, 1)));
    end
    // Both cards swap polarity; models follow, words must not move
    s0 <= 1'b1;
    s1 <= 1'b0;
    settle();
    rdr(8'h0c, rd, rs);
    chk(rd, {wb, wa});
    chk(32'(trq), 32'(dec(wa, 1)));
    $display("test bcd and polarity done");
    sb <= 1'b0;
    settle();
    chk(32'({perr, vld}), 32'h20);
    rdr(8'h08, rd, rs);
    chk(32'(rd[0]), 32'h1);
    sb <= 1'b1;
    wr(8'h00, 32'h02, rs);
    wr(8'h04, 32'h00323207, rs);
    pr1 <= 1'b0;
    settle();
    chk(32'({perr, vld}), 32'h0a);
    $display("test slots done");
    conclude();
  end
endmodule
